// [hw/tgc_pkg.sv]
// Constants, field layouts and carrier types of the timer compare/capture block
package tgc_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] TGC_OFF_COUNT   = 8'h00;
    localparam logic [7:0] TGC_OFF_GR_A    = 8'h04;
    localparam logic [7:0] TGC_OFF_GR_B    = 8'h08;
    localparam logic [7:0] TGC_OFF_BUF_A   = 8'h0c;
    localparam logic [7:0] TGC_OFF_BUF_B   = 8'h10;
    localparam logic [7:0] TGC_OFF_IOCTL   = 8'h14;
    localparam logic [7:0] TGC_OFF_MODE    = 8'h18;
    localparam logic [7:0] TGC_OFF_STATUS  = 8'h1c;
    localparam logic [7:0] TGC_OFF_IRQEN   = 8'h20;
    localparam logic [7:0] TGC_OFF_PORT    = 8'h24;

    // Reset values
    localparam logic [15:0] TGC_RST_COUNT  = 16'h0000;
    localparam logic [15:0] TGC_RST_GR     = 16'hffff;
    localparam logic [15:0] TGC_RST_BUF    = 16'hffff;
    localparam logic [7:0]  TGC_RST_IOCTL  = 8'h00;
    localparam logic [6:0]  TGC_RST_MODE   = 7'h00;
    localparam logic [3:0]  TGC_RST_PORT   = 4'h0;

    // Pin I/O control codes
    localparam logic [2:0] TGC_IO_OUT_NONE = 3'h0;
    localparam logic [2:0] TGC_IO_OUT_0    = 3'h1;
    localparam logic [2:0] TGC_IO_OUT_1    = 3'h2;
    localparam logic [2:0] TGC_IO_OUT_TGL  = 3'h3;
    localparam logic [2:0] TGC_IO_CAP_RISE = 3'h4;
    localparam logic [2:0] TGC_IO_CAP_FALL = 3'h5;

    // Counter clock selections
    localparam logic [2:0] TGC_CLK_DIV1    = 3'h0;
    localparam logic [2:0] TGC_CLK_DIV2    = 3'h1;
    localparam logic [2:0] TGC_CLK_DIV4    = 3'h2;
    localparam logic [2:0] TGC_CLK_DIV8    = 3'h3;
    localparam logic [2:0] TGC_CLK_EXT_R   = 3'h4;
    localparam logic [2:0] TGC_CLK_EXT_F   = 3'h5;

    // Counter clearing sources
    localparam logic [1:0] TGC_CLR_NONE    = 2'h0;
    localparam logic [1:0] TGC_CLR_A       = 2'h1;
    localparam logic [1:0] TGC_CLR_B       = 2'h2;

    // Channel indices
    localparam int TGC_CH_A = 0;
    localparam int TGC_CH_B = 1;

    // I/O control register layout, bits 7..0
    typedef struct packed {
        logic       buffer_enable_b;
        logic [2:0] pin_b_io_code;
        logic       buffer_enable_a;
        logic [2:0] pin_a_io_code;
    } tgc_ioctl_s;

    // Mode register layout, bits 6..0
    typedef struct packed {
        logic       count_enable;
        logic [2:0] clk_sel;
        logic [1:0] clr_sel;
        logic       pwm;
    } tgc_mode_s;

    // Pin function resolved from port and mode settings
    typedef enum logic [1:0] {
        TGC_FN_PORT,
        TGC_FN_COMPARE,
        TGC_FN_CAPTURE,
        TGC_FN_PWM
    } tgc_fn_e;

endpackage : tgc_pkg

// [hw/tgc_timer.sv]
// Timer general registers A/B with compare output, capture and APB slave
//
// Summary of operation
// - Two 16-bit registers, compare or capture
// - Compare equality sets the channel flag
// - Selected edge captures count, sets flag
// - PWM mode ignores I/O control codes
// - Two bits attach buffer A and B
// - Compare match A with buffer loads count
// - Capture with buffer shifts old value out
// - Reset: compare mode, registers all ones
// - Pin A outputs PWM when enabled
// - I/O code and direction pick pin function
// - Counter counts up: free, periodic, external
// - Match drives pin 0, 1 or toggle
// - Initial pin level set before first match
// - Same demanded level leaves pin unchanged
// - Match pulses in last equal cycle
// - One match per counter input clock
// - Capture edge rising, falling or both
// - Match or capture may clear counter
// - Flag clears on read-one then write-zero
// - Flag requests interrupt only when enabled
`timescale 1ns/10ps
module tgc_timer
    import tgc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic        timer_pin_a_in,
    output logic             timer_pin_a_out,
    output logic             timer_pin_a_oe,
    input  wire logic        timer_pin_b_in,
    output logic             timer_pin_b_out,
    output logic             timer_pin_b_oe,
    // External event clock
    input  wire logic        ext_clk_in,
    // Interrupt requests
    output logic             irq_req_a,
    output logic             irq_req_b
);

    // Resolve what a pin does from port and mode settings
    function automatic tgc_fn_e pin_function(input logic       port_mode_bit,
                                             input logic       port_direction_bit,
                                             input logic       pwm,
                                             input logic       is_a,
                                             input logic [2:0] code);
        tgc_fn_e fn;
        fn = TGC_FN_PORT;
        if (port_mode_bit) begin
            if (pwm) begin
                fn = is_a ? TGC_FN_PWM : TGC_FN_PORT;
            end else if (code == TGC_IO_OUT_0 || code[2:1] == 2'b01) begin
                fn = TGC_FN_COMPARE;
            end else if (code[2] && !port_direction_bit) begin
                fn = TGC_FN_CAPTURE;
            end
        end
        return fn;
    endfunction : pin_function

    // Edge qualification against a capture code
    function automatic logic edge_hit(input logic [2:0] code,
                                      input logic       prev,
                                      input logic       cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        return (code == TGC_IO_CAP_RISE) ? rise :
               (code == TGC_IO_CAP_FALL) ? fall : (rise | fall);
    endfunction : edge_hit

    // Pin level after a compare match
    function automatic logic match_level(input logic [2:0] code, input logic cur);
        return (code == TGC_IO_OUT_0) ? 1'b0 :
               (code == TGC_IO_OUT_1) ? 1'b1 : ~cur;
    endfunction : match_level

    logic [15:0] timer_count;
    logic [15:0] general_reg [2];
    logic [15:0] buffer_reg  [2];
    tgc_ioctl_s  io_control;
    tgc_mode_s   timer_mode_select;
    logic [1:0]  match_capture_flag;
    logic [1:0]  flag_read_one;
    logic [1:0]  match_capture_irq_en;
    logic [3:0]  port_bits;
    logic [2:0]  prescale;
    logic [1:0]  pin_level;

    // Synchronisers: s1 feeds only s2
    logic [2:0]  sync_s1;
    logic [2:0]  sync_s2;
    logic [2:0]  sync_prev;

    // Combinational helpers
    logic        wr_en;
    logic        rd_en;
    logic        count_tick;
    logic [1:0]  match_hit;
    logic [1:0]  capture_hit;
    logic [2:0]  code   [2];
    tgc_fn_e     pin_fn [2];
    tgc_ioctl_s  next_io;
    logic        ext_rise;
    logic        ext_fall;
    logic        clear_count;

    assign wr_en    = psel & penable & pready & pwrite;
    assign rd_en    = psel & penable & pready & ~pwrite;
    assign code[0]  = io_control.pin_a_io_code;
    assign code[1]  = io_control.pin_b_io_code;
    assign next_io  = tgc_ioctl_s'(pwdata[7:0]);
    assign ext_rise = sync_s2[2] & ~sync_prev[2];
    assign ext_fall = sync_prev[2] & ~sync_s2[2];

    always_comb begin
        pin_fn[0] = pin_function(port_bits[0], port_bits[1], timer_mode_select.pwm,
                                 1'b1, code[0]);
        pin_fn[1] = pin_function(port_bits[2], port_bits[3], timer_mode_select.pwm,
                                 1'b0, code[1]);
    end

    always_comb begin
        count_tick = 1'b0;
        if (timer_mode_select.count_enable) begin
            case (timer_mode_select.clk_sel)
                TGC_CLK_DIV1:  count_tick = 1'b1;
                TGC_CLK_DIV2:  count_tick = prescale[0];
                TGC_CLK_DIV4:  count_tick = &prescale[1:0];
                TGC_CLK_DIV8:  count_tick = &prescale;
                TGC_CLK_EXT_R: count_tick = ext_rise;
                TGC_CLK_EXT_F: count_tick = ext_fall;
                default:       count_tick = ext_rise | ext_fall;
            endcase
        end
    end

    // Matches and captures per channel
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // match in the last equal cycle, once per tick
            match_hit[i] = count_tick && (timer_count == general_reg[i]) &&
                           (pin_fn[i] == TGC_FN_COMPARE ||
                            (timer_mode_select.pwm && pin_fn[i] != TGC_FN_CAPTURE) ||
                            pin_fn[i] == TGC_FN_PORT && !code[i][2]);
            // capture on the selected edge, not in PWM
            capture_hit[i] = (pin_fn[i] == TGC_FN_CAPTURE) &&
                             edge_hit(code[i], sync_prev[i], sync_s2[i]);
        end
    end

    always_comb begin
        case (timer_mode_select.clr_sel)
            TGC_CLR_A: clear_count = match_hit[TGC_CH_A] | capture_hit[TGC_CH_A];
            TGC_CLR_B: clear_count = match_hit[TGC_CH_B] | capture_hit[TGC_CH_B];
            default:   clear_count = 1'b0;
        endcase
    end

    // two-stage synchronisers, then an edge-history stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_s1   <= 3'h0;
            sync_s2   <= 3'h0;
            sync_prev <= 3'h0;
        end else begin
            sync_s1   <= {ext_clk_in, timer_pin_b_in, timer_pin_a_in};
            sync_s2   <= sync_s1;
            sync_prev <= sync_s2;
        end
    end

    // Free-running prescaler
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prescale <= 3'h0;
        end else begin
            prescale <= prescale + 3'h1;
        end
    end

    // up counter; software write wins over counting
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            timer_count <= TGC_RST_COUNT;
        end else if (wr_en && paddr == TGC_OFF_COUNT) begin
            timer_count <= pwdata[15:0];
        end else if (clear_count) begin
            timer_count <= TGC_RST_COUNT;
        end else if (count_tick) begin
            timer_count <= timer_count + 16'h0001;
        end
    end

    // General and buffer registers; hardware loads win over software
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                general_reg[i] <= TGC_RST_GR;
                buffer_reg[i]  <= TGC_RST_BUF;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (capture_hit[i]) begin
                    general_reg[i] <= timer_count;
                    if (i == 0 ? io_control.buffer_enable_a : io_control.buffer_enable_b) begin
                        buffer_reg[i] <= general_reg[i];
                    end
                // buffered compare A reloads from count
                end else if (i == 0 && match_hit[i] && io_control.buffer_enable_a &&
                             pin_fn[i] == TGC_FN_COMPARE) begin
                    general_reg[i] <= timer_count;
                end else if (wr_en && paddr == (i == 0 ? TGC_OFF_GR_A : TGC_OFF_GR_B)) begin
                    general_reg[i] <= pwdata[15:0];
                end
                if (!capture_hit[i] && wr_en &&
                    paddr == (i == 0 ? TGC_OFF_BUF_A : TGC_OFF_BUF_B)) begin
                    buffer_reg[i] <= pwdata[15:0];
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            io_control           <= tgc_ioctl_s'(TGC_RST_IOCTL);
            timer_mode_select    <= tgc_mode_s'(TGC_RST_MODE);
            match_capture_irq_en <= 2'h0;
            port_bits            <= TGC_RST_PORT;
        end else if (wr_en) begin
            if (paddr == TGC_OFF_IOCTL) begin
                io_control <= next_io;
            end else if (paddr == TGC_OFF_MODE) begin
                timer_mode_select <= tgc_mode_s'(pwdata[6:0]);
            end else if (paddr == TGC_OFF_IRQEN) begin
                match_capture_irq_en <= pwdata[1:0];
            end else if (paddr == TGC_OFF_PORT) begin
                port_bits <= pwdata[3:0];
            end
        end
    end

    // Flags: set wins over the software clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            match_capture_flag <= 2'h0;
            flag_read_one      <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (match_hit[i] || capture_hit[i]) begin
                    match_capture_flag[i] <= 1'b1;
                // clear needs prior read of one
                end else if (wr_en && paddr == TGC_OFF_STATUS && !pwdata[i] &&
                             flag_read_one[i]) begin
                    match_capture_flag[i] <= 1'b0;
                end
                if (rd_en && paddr == TGC_OFF_STATUS && match_capture_flag[i]) begin
                    flag_read_one[i] <= 1'b1;
                end else if (wr_en && paddr == TGC_OFF_STATUS) begin
                    flag_read_one[i] <= 1'b0;
                end
            end
        end
    end

    // Pin output levels
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // toggle starts from 0 after reset
            pin_level <= 2'h0;
        end else if (wr_en && paddr == TGC_OFF_MODE && pwdata[0] &&
                     !timer_mode_select.pwm) begin
            // PWM start level follows the clearing source
            pin_level[0] <= (pwdata[2:1] == TGC_CLR_A);
        end else if (timer_mode_select.pwm) begin
            // set on A, clear on B; equal matches keep the level
            if (match_hit[0] && !match_hit[1]) begin
                pin_level[0] <= 1'b1;
            end else if (match_hit[1] && !match_hit[0]) begin
                pin_level[0] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_en && paddr == TGC_OFF_IOCTL &&
                    (i == 0 ? next_io.pin_a_io_code : next_io.pin_b_io_code) != code[i]) begin
                    case (i == 0 ? next_io.pin_a_io_code : next_io.pin_b_io_code)
                        TGC_IO_OUT_0: pin_level[i] <= 1'b1;
                        TGC_IO_OUT_1: pin_level[i] <= 1'b0;
                        default:      pin_level[i] <= pin_level[i];
                    endcase
                end else if (match_hit[i] && pin_fn[i] == TGC_FN_COMPARE) begin
                    pin_level[i] <= match_level(code[i], pin_level[i]);
                end
            end
        end
    end

    // Registered pin drivers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            timer_pin_a_out <= 1'b0;
            timer_pin_a_oe  <= 1'b0;
            timer_pin_b_out <= 1'b0;
            timer_pin_b_oe  <= 1'b0;
        end else begin
            timer_pin_a_out <= pin_level[0];
            timer_pin_a_oe  <= (pin_fn[0] == TGC_FN_COMPARE) || (pin_fn[0] == TGC_FN_PWM);
            timer_pin_b_out <= pin_level[1];
            timer_pin_b_oe  <= (pin_fn[1] == TGC_FN_COMPARE);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_req_a <= 1'b0;
            irq_req_b <= 1'b0;
        end else begin
            irq_req_a <= match_capture_flag[0] & match_capture_irq_en[0];
            irq_req_b <= match_capture_flag[1] & match_capture_irq_en[1];
        end
    end

    // APB: read data prepared in setup, answered in the first access cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == TGC_OFF_COUNT) begin
                    prdata <= {16'h0000, timer_count};
                end else if (paddr == TGC_OFF_GR_A) begin
                    prdata <= {16'h0000, general_reg[0]};
                end else if (paddr == TGC_OFF_GR_B) begin
                    prdata <= {16'h0000, general_reg[1]};
                end else if (paddr == TGC_OFF_BUF_A) begin
                    prdata <= {16'h0000, buffer_reg[0]};
                end else if (paddr == TGC_OFF_BUF_B) begin
                    prdata <= {16'h0000, buffer_reg[1]};
                end else if (paddr == TGC_OFF_IOCTL) begin
                    prdata <= {24'h000000, io_control};
                end else if (paddr == TGC_OFF_MODE) begin
                    prdata <= {25'h0, timer_mode_select};
                end else if (paddr == TGC_OFF_STATUS) begin
                    prdata <= {30'h0, match_capture_flag};
                end else if (paddr == TGC_OFF_IRQEN) begin
                    prdata <= {30'h0, match_capture_irq_en};
                end else if (paddr == TGC_OFF_PORT) begin
                    prdata <= {28'h0000000, port_bits};
                end else begin
                    // Unmapped: error, reads zero, writes dropped
                    pslverr <= 1'b1;
                end
                if (pwrite) begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

endmodule : tgc_timer

// [tb/tgc_pin_model.sv]
// Loads and capture sources facing the two timer pins
`timescale 1ns/10ps
module tgc_pin_model (
    // Pin side of the block
    input  wire logic timer_pin_a_out,
    input  wire logic timer_pin_a_oe,
    input  wire logic timer_pin_b_out,
    input  wire logic timer_pin_b_oe,
    output logic      timer_pin_a_in,
    output logic      timer_pin_b_in,
    output logic      ext_clk_in,
    // Source levels asked for by the bench
    input  wire logic src_a,
    input  wire logic src_b
);
    // Block wins the wire while it drives
    assign timer_pin_a_in = timer_pin_a_oe ? timer_pin_a_out : src_a;
    assign timer_pin_b_in = timer_pin_b_oe ? timer_pin_b_out : src_b;
    // No external event counting here, so the event clock stays quiet
    assign ext_clk_in     = 1'b0;
endmodule : tgc_pin_model

// [tb/tgc_timer_properties.sv]
// Port-level properties of the timer compare/capture block
`timescale 1ns/10ps
module tgc_timer_properties (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and requests
    input wire logic        timer_pin_a_oe,
    input wire logic        timer_pin_b_oe,
    input wire logic        irq_req_a,
    input wire logic        irq_req_b
);
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_ANSWER_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_UPPER_ZERO: assert property (prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    AST_RESET_OUTS: assert property ($rose(rst_n) |->
        !pready && !timer_pin_a_oe && !timer_pin_b_oe && !irq_req_a && !irq_req_b)
        else $error("outputs active after reset");
    AST_IRQ_FALL_A: assert property ($fell(irq_req_a) |-> !$past(rst_n) ||
        $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("request a dropped without write");
    AST_IRQ_FALL_B: assert property ($fell(irq_req_b) |-> !$past(rst_n) ||
        $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("request b dropped without write");
    AST_OE_RISE_A: assert property ($rose(timer_pin_a_oe) |->
        $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("pin a driven without setting");

    cover property (pslverr);
    cover property ($fell(irq_req_a));
    cover property ($rose(timer_pin_a_oe));
endmodule : tgc_timer_properties

bind tgc_timer tgc_timer_properties u_tgc_timer_properties (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin_a_oe(timer_pin_a_oe),
    .timer_pin_b_oe(timer_pin_b_oe), .irq_req_a(irq_req_a), .irq_req_b(irq_req_b)
);

// [tb/tgc_timer_bench.sv]
// Self-checking bench of the timer compare/capture block
`timescale 1ns/10ps
module tgc_timer_bench
    import tgc_pkg::*;
;
    typedef struct packed {
        logic [31:0] data;
        logic        err;
    } tgc_exp_s;
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        src_a   = 1'b0;
    logic        src_b   = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_clk_in, irq_a, irq_b;
    logic        pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    tgc_exp_s    exq[$];
    tgc_exp_s    seen;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [15:0] exp_gr, exp_buf, v1, v2;
    logic [2:0]  code;

    always #5 clk_sys = ~clk_sys;

    tgc_timer u_tgc_timer (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_pin_a_in(pa_in), .timer_pin_a_out(pa_out), .timer_pin_a_oe(pa_oe),
        .timer_pin_b_in(pb_in), .timer_pin_b_out(pb_out), .timer_pin_b_oe(pb_oe),
        .ext_clk_in(ext_clk_in), .irq_req_a(irq_a), .irq_req_b(irq_b)
    );
    tgc_pin_model u_tgc_pin_model (
        .timer_pin_a_out(pa_out), .timer_pin_a_oe(pa_oe), .timer_pin_b_out(pb_out),
        .timer_pin_b_oe(pb_oe), .timer_pin_a_in(pa_in), .timer_pin_b_in(pb_in),
        .ext_clk_in(ext_clk_in), .src_a(src_a), .src_b(src_b)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic er);
        exq.push_back('{ex, er});
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, ex, 1'b0);
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt

    task automatic test_done();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // Answers are matched in order against the noted expectations
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            seen = exq.pop_front();
            chk(prdata, seen.data);
            chk({31'h0, pslverr}, {31'h0, seen.err});
        end
    end

    initial begin
        wt(20000);
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(13));
        wt(2);
        rst_n <= 1'b1;
        rd(TGC_OFF_GR_A, 32'hffff);
        rd(TGC_OFF_GR_B, 32'hffff);
        rd(TGC_OFF_COUNT, 32'h0);
        apb(1'b0, 8'h28, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h28, 32'h5, 32'h0, 1'b1);
        // Compare outputs: a sets 1, b sets 0
        wr(TGC_OFF_GR_A, 32'h14);
        wr(TGC_OFF_GR_B, 32'h28);
        wr(TGC_OFF_PORT, 32'h5);
        wr(TGC_OFF_IOCTL, 32'h12);
        wt(3);
        chk({28'h0, pa_oe, pa_out, pb_oe, pb_out}, 32'hb);
        for (int k = 0; k < 2; k++) begin
            wr(TGC_OFF_COUNT, 32'h0);
            wr(TGC_OFF_MODE, 32'h40);
            wt(60);
            chk({28'h0, pa_oe, pa_out, pb_oe, pb_out}, 32'he);
        end
        wr(TGC_OFF_MODE, 32'h0);
        // Flag clear needs a read of one first
        wr(TGC_OFF_STATUS, 32'h0);
        rd(TGC_OFF_STATUS, 32'h3);
        chk({30'h0, irq_a, irq_b}, 32'h0);
        wr(TGC_OFF_IRQEN, 32'h3);
        wt(2);
        chk({30'h0, irq_a, irq_b}, 32'h3);
        wr(TGC_OFF_STATUS, 32'h0);
        wt(2);
        rd(TGC_OFF_STATUS, 32'h0);
        chk({30'h0, irq_a, irq_b}, 32'h0);
        // Toggle keeps the prior level until the next match
        wr(TGC_OFF_IOCTL, 32'h13);
        wt(3);
        chk({31'h0, pa_out}, 32'h1);
        wr(TGC_OFF_COUNT, 32'h0);
        wr(TGC_OFF_MODE, 32'h40);
        wt(60);
        wr(TGC_OFF_MODE, 32'h0);
        chk({31'h0, pa_out}, 32'h0);
        // Both matches flagged again; clear them so capture alone sets a
        rd(TGC_OFF_STATUS, 32'h3);
        wr(TGC_OFF_STATUS, 32'h0);
        // Buffered capture on each edge selection, counter held still
        exp_gr  = 16'h0014;
        exp_buf = 16'hffff;
        for (int i = 4; i < 7; i++) begin
            code = 3'(i);
            v1   = 16'($urandom);
            v2   = 16'($urandom);
            wr(TGC_OFF_IOCTL, {24'h0, 5'h03, code});
            wr(TGC_OFF_COUNT, {16'h0, v1});
            src_a <= 1'b1;
            wt(8);
            wr(TGC_OFF_COUNT, {16'h0, v2});
            src_a <= 1'b0;
            wt(8);
            if (code != TGC_IO_CAP_FALL) begin
                exp_buf = exp_gr;
                exp_gr  = v1;
            end
            if (code != TGC_IO_CAP_RISE) begin
                exp_buf = exp_gr;
                exp_gr  = v2;
            end
            rd(TGC_OFF_GR_A, {16'h0, exp_gr});
            rd(TGC_OFF_BUF_A, {16'h0, exp_buf});
        end
        rd(TGC_OFF_STATUS, 32'h1);
        // Periodic count cleared by match b: 103 ticks over 41 states leave 21
        wr(TGC_OFF_COUNT, 32'h0);
        wr(TGC_OFF_MODE, 32'h44);
        wt(100);
        wr(TGC_OFF_MODE, 32'h0);
        rd(TGC_OFF_COUNT, 32'h15);
        // Waveform mode overrides the capture code on pin a
        wr(TGC_OFF_MODE, 32'h1);
        wt(3);
        chk({30'h0, pa_oe, pa_out}, 32'h2);
        test_done();
    end
endmodule : tgc_timer_bench
